// *** design/sfr_bank3_pkg.sv ***
// constants, types and decode shared by the bank-3 register block
// assumes one core clock; all indices are 9-bit data-memory addresses
package sfr_bank3_pkg;
	localparam int DATA_W  = 8;
	localparam int ADDR_W  = 9;
	localparam int OFFS_W  = 7;
	localparam int NIB_W   = 4;
	localparam int PADDR_W = 12;

	// register indices; byte address on the bus is four times the index
	localparam logic [8:0] IDX_INDIRECT  = 9'h180;
	localparam logic [8:0] IDX_OPTIONS   = 9'h181;
	localparam logic [8:0] IDX_PC_LOW    = 9'h182;
	localparam logic [8:0] IDX_STATUS    = 9'h183;
	localparam logic [8:0] IDX_POINTER   = 9'h184;
	localparam logic [8:0] IDX_DIRECTION = 9'h186;
	localparam logic [8:0] IDX_PC_HIGH   = 9'h18a;
	localparam logic [8:0] IDX_INT_CTRL  = 9'h18b;
	// index bits 8:5 common to the whole region 0x180..0x19f
	localparam logic [3:0] REGION_TOP    = 4'hc;

	localparam int ST_C      = 0;
	localparam int ST_NIBBLE = 1;
	localparam int ST_Z      = 2;
	localparam int ST_SLEEP  = 3;
	localparam int ST_WDOG   = 4;
	localparam int ST_BANK0  = 5;
	localparam int ST_BANK1  = 6;
	localparam int ST_IBANK  = 7;

	localparam logic [7:0] STATUS_RST    = 8'h18;
	localparam logic [7:0] OPTIONS_RST   = 8'hff;
	localparam logic [7:0] DIRECTION_RST = 8'hff;
	localparam logic [7:0] PC_LOW_RST    = 8'h00;
	localparam logic [7:0] PC_HIGH_RST   = 8'h00;
	localparam logic [7:0] INT_CTRL_RST  = 8'h00;
	localparam logic [7:0] POINTER_RST   = 8'h00;
	localparam logic [7:0] PC_HIGH_MASK  = 8'h1f;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_INDIRECT, SEL_OPTIONS, SEL_PC_LOW, SEL_STATUS,
		SEL_POINTER, SEL_DIRECTION, SEL_PC_HIGH, SEL_INT_CTRL
	} sel_type;

	typedef enum logic [2:0] {
		OP_MOVE, OP_LOGIC, OP_ADD, OP_SUB, OP_CLEAR
	} alu_op_type;

	// core registers match in every bank, option/direction in banks 1 and 3
	function automatic sel_type decode_sel(input logic [ADDR_W-1:0] a);
		logic [OFFS_W-1:0] o;
		o = a[OFFS_W-1:0];
		decode_sel = SEL_NONE;
		if (o == IDX_INDIRECT[OFFS_W-1:0])
			decode_sel = SEL_INDIRECT;
		else if (o == IDX_PC_LOW[OFFS_W-1:0])
			decode_sel = SEL_PC_LOW;
		else if (o == IDX_STATUS[OFFS_W-1:0])
			decode_sel = SEL_STATUS;
		else if (o == IDX_POINTER[OFFS_W-1:0])
			decode_sel = SEL_POINTER;
		else if (o == IDX_PC_HIGH[OFFS_W-1:0])
			decode_sel = SEL_PC_HIGH;
		else if (o == IDX_INT_CTRL[OFFS_W-1:0])
			decode_sel = SEL_INT_CTRL;
		else if (a[OFFS_W] && o == IDX_OPTIONS[OFFS_W-1:0])
			decode_sel = SEL_OPTIONS;
		else if (a[OFFS_W] && o == IDX_DIRECTION[OFFS_W-1:0])
			decode_sel = SEL_DIRECTION;
	endfunction
endpackage

// *** design/sfr_address_map.sv ***
// forms the data-memory address of a file operand and decodes it
// assumes the bank bits and pointer come straight from their registers
`timescale 1ns/1ps
module sfr_address_map
	import sfr_bank3_pkg::*;
(
	input  wire logic [OFFS_W-1:0] direct_offset,
	input  wire logic [1:0]        bank_sel,
	input  wire logic              indirect_bank,
	input  wire logic [DATA_W-1:0] pointer,
	output logic      [ADDR_W-1:0] effective_address,
	output sel_type                reg_sel
);
	wire use_pointer = direct_offset == IDX_INDIRECT[OFFS_W-1:0];

	assign effective_address = use_pointer ? {indirect_bank, pointer}
		: {bank_sel, direct_offset};
	assign reg_sel = decode_sel(effective_address);
endmodule

// *** design/status_flag_logic.sv ***
// ALU result and flag generation for the ops that reach file registers
// assumes operand_a is the minuend and the core's value for move/logic
`timescale 1ns/1ps
module status_flag_logic
	import sfr_bank3_pkg::*;
(
	input  alu_op_type             op,
	input  wire logic [DATA_W-1:0] operand_a,
	input  wire logic [DATA_W-1:0] operand_b,
	output logic      [DATA_W-1:0] result,
	output logic                   zero_flag,
	output logic                   nibble_carry_flag,
	output logic                   carry_flag,
	output logic                   update_zero,
	output logic                   update_nibble,
	output logic                   update_carry
);
	wire is_sub = op == OP_SUB;
	// subtract as add of the complement plus one: carries become not-borrow
	wire [DATA_W-1:0] addend = is_sub ? ~operand_b : operand_b;
	wire [DATA_W:0]   full_sum = {1'b0, operand_a} + {1'b0, addend}
		+ {{DATA_W{1'b0}}, is_sub};
	wire [NIB_W:0]    nib_sum = {1'b0, operand_a[NIB_W-1:0]}
		+ {1'b0, addend[NIB_W-1:0]} + {{NIB_W{1'b0}}, is_sub};
	wire arith = op == OP_ADD || is_sub;

	assign result = arith ? full_sum[DATA_W-1:0]
		: (op == OP_CLEAR) ? {DATA_W{1'b0}} : operand_a;
	assign zero_flag         = result == {DATA_W{1'b0}};
	assign carry_flag        = full_sum[DATA_W];
	assign nibble_carry_flag = nib_sum[NIB_W];
	assign update_zero       = op != OP_MOVE;
	assign update_nibble     = arith;
	assign update_carry      = arith;
endmodule

// *** design/bank3_sfr_map_status_reg.sv ***
// bank-3 special-function registers with the status write protection
// assumes an APB master for software and one core op presented per cycle
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module bank3_sfr_map_status_reg
	import sfr_bank3_pkg::*;
(
	input  wire logic                                core_clk,
	input  wire logic                                reset,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [sfr_bank3_pkg::PADDR_W-1:0]   paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                core_op_valid,
	input  sfr_bank3_pkg::alu_op_type                core_op,
	input  wire logic [sfr_bank3_pkg::OFFS_W-1:0]    core_file_offset,
	input  wire logic [sfr_bank3_pkg::DATA_W-1:0]    core_operand_a,
	input  wire logic [sfr_bank3_pkg::DATA_W-1:0]    core_operand_b,
	input  wire logic                                core_write_file,
	input  wire logic                                wdt_timeout_event,
	input  wire logic                                sleep_event,
	input  wire logic                                wdt_clear_event,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    core_read_data,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    alu_result,
	output logic      [sfr_bank3_pkg::ADDR_W-1:0]    effective_address,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    processor_status,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    timer_and_pullup_options,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    program_counter_low,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    indirect_pointer,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    port_b_direction,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    program_counter_high_buffer,
	output logic      [sfr_bank3_pkg::DATA_W-1:0]    interrupt_control
);
	import sfr_bank3_pkg::*;

	sel_type             core_sel;
	sel_type             apb_sel;
	sel_type             wr_sel;
	logic [DATA_W-1:0]   flag_result;
	logic                flag_z;
	logic                flag_nibble;
	logic                flag_c;
	logic                upd_z;
	logic                upd_nibble;
	logic                upd_c;
	logic [DATA_W-1:0]   next_status;

	// direct bank bits and indirect bank bit live in the status register
	sfr_address_map u_map (
		.direct_offset     (core_file_offset),
		.bank_sel          (processor_status[ST_BANK1:ST_BANK0]),
		.indirect_bank     (processor_status[ST_IBANK]),
		.pointer           (indirect_pointer),
		.effective_address (effective_address),
		.reg_sel           (core_sel)
	);

	status_flag_logic u_flags (
		.op                (core_op),
		.operand_a         (core_operand_a),
		.operand_b         (core_operand_b),
		.result            (flag_result),
		.zero_flag         (flag_z),
		.nibble_carry_flag (flag_nibble),
		.carry_flag        (flag_c),
		.update_zero       (upd_z),
		.update_nibble     (upd_nibble),
		.update_carry      (upd_c)
	);

	// bus side: word index, region hit and access phase
	wire [ADDR_W-1:0] apb_index  = paddr[ADDR_W+1:2];
	wire              apb_hit    = !paddr[PADDR_W-1] && apb_index[ADDR_W-1:5] == REGION_TOP;
	wire              apb_access = psel && penable;
	// core ops own the cycle; a bus access just waits, so a core that
	// issues ops every cycle starves software
	assign pready  = !core_op_valid;
	assign pslverr = apb_access && !apb_hit;
	assign apb_sel = apb_hit ? decode_sel(apb_index) : SEL_NONE;

	wire apb_wr   = apb_access && pready && pwrite && apb_hit;
	wire core_wr  = core_op_valid && core_write_file;
	wire wr_any   = core_wr || apb_wr;
	assign wr_sel = core_wr ? core_sel : apb_sel;
	wire [DATA_W-1:0] wr_data = core_wr ? flag_result : pwdata[DATA_W-1:0];

	wire wr_status    = wr_any && wr_sel == SEL_STATUS;
	wire wr_options   = wr_any && wr_sel == SEL_OPTIONS;
	wire wr_pc_low    = wr_any && wr_sel == SEL_PC_LOW;
	wire wr_pointer   = wr_any && wr_sel == SEL_POINTER;
	wire wr_direction = wr_any && wr_sel == SEL_DIRECTION;
	wire wr_pc_high   = wr_any && wr_sel == SEL_PC_HIGH;
	wire wr_int_ctrl  = wr_any && wr_sel == SEL_INT_CTRL;

	// any flag-touching op locks all three arithmetic bits against data
	wire flag_op     = core_op_valid && (upd_z || upd_nibble || upd_c);
	wire data_flags  = wr_status && !(core_wr && flag_op);

	// read view; indirect port is not storage and holes read zero
	function automatic logic [DATA_W-1:0] read_reg(input sel_type s);
		read_reg = {DATA_W{1'b0}};
		unique case (s)
			SEL_NONE:      read_reg = {DATA_W{1'b0}};
			SEL_INDIRECT:  read_reg = {DATA_W{1'b0}};
			SEL_OPTIONS:   read_reg = timer_and_pullup_options;
			SEL_PC_LOW:    read_reg = program_counter_low;
			SEL_STATUS:    read_reg = processor_status;
			SEL_POINTER:   read_reg = indirect_pointer;
			SEL_DIRECTION: read_reg = port_b_direction;
			SEL_PC_HIGH:   read_reg = program_counter_high_buffer;
			SEL_INT_CTRL:  read_reg = interrupt_control;
		endcase
	endfunction

	assign prdata = {{(32-DATA_W){1'b0}}, read_reg(apb_sel)};

	// one status register: bank bits, reset cause and ALU flags
	always_comb begin
		next_status = processor_status;
		if (wr_status) begin
			next_status[ST_IBANK:ST_BANK0] = wr_data[ST_IBANK:ST_BANK0];
		end
		if (data_flags) begin
			next_status[ST_Z:ST_C] = wr_data[ST_Z:ST_C];
		end
		if (core_op_valid && upd_z) begin
			next_status[ST_Z] = flag_z;
		end
		if (core_op_valid && upd_nibble) begin
			next_status[ST_NIBBLE] = flag_nibble;
		end
		if (core_op_valid && upd_c) begin
			next_status[ST_C] = flag_c;
		end
		// reset-cause bits move only on their own events, never on writes
		if (wdt_clear_event || sleep_event) begin
			next_status[ST_WDOG] = 1'b1;
		end
		if (wdt_timeout_event) begin
			next_status[ST_WDOG] = 1'b0;
		end
		if (wdt_clear_event) begin
			next_status[ST_SLEEP] = 1'b1;
		end
		if (sleep_event) begin
			next_status[ST_SLEEP] = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			processor_status <= STATUS_RST;
		end else begin
			processor_status <= next_status;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			timer_and_pullup_options <= OPTIONS_RST;
			port_b_direction         <= DIRECTION_RST;
		end else begin
			if (wr_options) begin
				timer_and_pullup_options <= wr_data;
			end
			if (wr_direction) begin
				port_b_direction <= wr_data;
			end
		end
	end

	// shared core registers: one copy whichever bank addressed them
	always_ff @(posedge core_clk) begin
		if (reset) begin
			program_counter_low         <= PC_LOW_RST;
			indirect_pointer            <= POINTER_RST;
			program_counter_high_buffer <= PC_HIGH_RST;
			interrupt_control           <= INT_CTRL_RST;
		end else begin
			if (wr_pc_low) begin
				program_counter_low <= wr_data;
			end
			if (wr_pointer) begin
				indirect_pointer <= wr_data;
			end
			if (wr_pc_high) begin
				program_counter_high_buffer <= wr_data & PC_HIGH_MASK;
			end
			if (wr_int_ctrl) begin
				interrupt_control <= wr_data;
			end
		end
	end

	// core sees the addressed register one cycle after presenting it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			core_read_data <= {DATA_W{1'b0}};
			alu_result     <= {DATA_W{1'b0}};
		end else begin
			core_read_data <= read_reg(core_sel);
			if (core_op_valid) begin
				alu_result <= flag_result;
			end
		end
	end

	// checks
	AST_HOLES_READ_ZERO: assert property (@(posedge core_clk) disable iff (reset)
		apb_access && apb_hit && apb_sel == SEL_NONE |-> prdata == 32'h0000_0000)
		else $error("unimplemented bus address read nonzero");

	AST_STATUS_ON_BUS: assert property (@(posedge core_clk) disable iff (reset)
		apb_access && apb_sel == SEL_STATUS && !pwrite
		|-> prdata[DATA_W-1:0] == processor_status)
		else $error("status read does not show the status register");

	AST_MOVE_TO_STATUS: assert property (@(posedge core_clk) disable iff (reset)
		core_wr && core_sel == SEL_STATUS && core_op == OP_MOVE
		|=> processor_status[ST_IBANK:ST_BANK0] == $past(core_operand_a[ST_IBANK:ST_BANK0])
			&& processor_status[ST_Z:ST_C] == $past(core_operand_a[ST_Z:ST_C]))
		else $error("move into status did not store the data");

	AST_FLAGS_FROM_LOGIC: assert property (@(posedge core_clk) disable iff (reset)
		core_wr && core_sel == SEL_STATUS && (core_op == OP_ADD || core_op == OP_SUB)
		|=> processor_status[ST_Z:ST_C] == $past({flag_z, flag_nibble, flag_c}))
		else $error("arithmetic write into status overrode the flag logic");

	AST_CAUSE_IGNORES_WRITES: assert property (@(posedge core_clk) disable iff (reset)
		!wdt_timeout_event && !sleep_event && !wdt_clear_event
		|=> processor_status[ST_WDOG:ST_SLEEP] == $past(processor_status[ST_WDOG:ST_SLEEP]))
		else $error("reset-cause flags changed without their event");

	AST_SLEEP_CAUSE: assert property (@(posedge core_clk) disable iff (reset)
		sleep_event && !wdt_timeout_event && !wdt_clear_event
		|=> processor_status[ST_WDOG:ST_SLEEP] == 2'h2)
		else $error("sleep entry did not mark the reset-cause flags");

	AST_CLEAR_STATUS: assert property (@(posedge core_clk) disable iff (reset)
		core_wr && core_sel == SEL_STATUS && core_op == OP_CLEAR
		|=> processor_status[ST_IBANK:ST_BANK0] == 3'h0 && processor_status[ST_Z]
			&& processor_status[ST_NIBBLE:ST_C] == $past(processor_status[ST_NIBBLE:ST_C]))
		else $error("clear of status gave the wrong pattern");

	AST_BORROW_SENSE: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_op == OP_SUB
		|=> processor_status[ST_C] == ($past(core_operand_a) >= $past(core_operand_b))
			&& processor_status[ST_NIBBLE]
				== ($past(core_operand_a[NIB_W-1:0]) >= $past(core_operand_b[NIB_W-1:0])))
		else $error("subtract carry is not an inverted borrow");

	AST_DIRECT_BANK: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_file_offset != IDX_INDIRECT[OFFS_W-1:0]
		|-> effective_address
			== {processor_status[ST_BANK1:ST_BANK0], core_file_offset})
		else $error("direct address does not follow the bank bits");

	AST_CORE_ALIAS: assert property (@(posedge core_clk) disable iff (reset)
		core_wr && core_sel == SEL_POINTER
		|=> indirect_pointer == $past(flag_result))
		else $error("pointer not shared across banks");

	AST_POINTER_ANY_BANK: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid
		&& core_file_offset == IDX_POINTER[OFFS_W-1:0]
		|-> core_sel == SEL_POINTER)
		else $error("pointer offset missed in some bank");

	AST_BUS_POINTER_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		apb_wr && apb_sel == SEL_POINTER
		|=> indirect_pointer
			== $past(pwdata[DATA_W-1:0]))
		else $error("bus write to pointer lost");

	AST_BUS_STATUS_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		apb_wr && apb_sel == SEL_STATUS
		|=> processor_status[ST_IBANK:ST_BANK0]
			== $past(pwdata[ST_IBANK:ST_BANK0])
			&& processor_status[ST_Z:ST_C]
			== $past(pwdata[ST_Z:ST_C]))
		else $error("bus write to status lost");

	AST_TIMEOUT_CAUSE: assert property (@(posedge core_clk) disable iff (reset)
		wdt_timeout_event
		|=> !processor_status[ST_WDOG])
		else $error("timeout did not clear the watchdog flag");

	AST_WDOG_CLEAR_CAUSE: assert property (@(posedge core_clk) disable iff (reset)
		wdt_clear_event && !wdt_timeout_event
		&& !sleep_event
		|=> processor_status[ST_WDOG:ST_SLEEP] == 2'h3)
		else $error("watchdog clear did not set both cause flags");

	AST_LOGIC_FLAGS: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_op == OP_LOGIC
		|=> processor_status[ST_Z]
			== ($past(core_operand_a) == 8'h00)
			&& processor_status[ST_NIBBLE:ST_C]
			== $past(processor_status[ST_NIBBLE:ST_C]))
		else $error("logic op flags wrong");

	AST_ADD_CARRY: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_op == OP_ADD
		|=> processor_status[ST_C] == ({1'b0, $past(core_operand_a)} + {1'b0, $past(core_operand_b)} > 9'h0ff))
		else $error("add carry wrong");

	AST_MOVE_KEEPS_FLAGS: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_op == OP_MOVE
		&& !(core_wr && core_sel == SEL_STATUS)
		|=> processor_status[ST_Z:ST_C] == $past(processor_status[ST_Z:ST_C]))
		else $error("move changed a flag");

	AST_CORE_HOLE_READ: assert property (@(posedge core_clk) disable iff (reset)
		core_sel == SEL_NONE || core_sel == SEL_INDIRECT
		|=> core_read_data == 8'h00)
		else $error("core read of a hole nonzero");

	AST_HOLE_WRITE_DROPPED: assert property (@(posedge core_clk) disable iff (reset)
		core_wr && core_sel == SEL_NONE
		|=> $stable(indirect_pointer)
			&& $stable(program_counter_low)
			&& $stable(interrupt_control))
		else $error("write to a hole changed a register");

	AST_PC_HIGH_WIDTH: assert property (@(posedge core_clk) disable iff (reset)
		core_wr && core_sel == SEL_PC_HIGH
		|=> (program_counter_high_buffer & ~PC_HIGH_MASK) == 8'h00)
		else $error("high buffer kept unused bits");

	AST_INDIRECT_ADDRESS: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_file_offset == IDX_INDIRECT[OFFS_W-1:0]
		|-> effective_address
			== {processor_status[ST_IBANK], indirect_pointer})
		else $error("indirect address ignores the pointer");

	AST_OUTSIDE_ERROR: assert property (@(posedge core_clk) disable iff (reset)
		apb_access && !apb_hit
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("outside access not refused");

	AST_CLEAR_ZERO_RESULT: assert property (@(posedge core_clk) disable iff (reset)
		core_op_valid && core_op == OP_CLEAR
		|=> alu_result == 8'h00 && processor_status[ST_Z])
		else $error("clear did not give zero");
endmodule

// *** sim/core_exec_model.sv ***
// core-side model: file ops and watchdog/sleep pulses fed to the bank
// assumes the bench queues work with issue(); gap idles between items
`timescale 1ns/1ps
module core_exec_model
	import sfr_bank3_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	output logic                   core_op_valid,
	output alu_op_type             core_op,
	output logic      [OFFS_W-1:0] core_file_offset,
	output logic      [DATA_W-1:0] core_operand_a,
	output logic      [DATA_W-1:0] core_operand_b,
	output logic                   core_write_file,
	output logic                   wdt_timeout_event,
	output logic                   sleep_event,
	output logic                   wdt_clear_event
);
	typedef struct {
		int         kind;
		alu_op_type op;
		int         off;
		int         a;
		int         b;
		bit         wr;
	} item_type;
	item_type work_q[$];
	item_type cur;
	int       gap = 0;
	int       wait_left = 0;

	// kind 0 file op, 1 timeout, 2 sleep entry, 3 watchdog clear
	// flag-setting ops on status only when a test asks for them
	task automatic issue(input int kind, input alu_op_type op, input int off, input int a, input int b,
		input bit wr);
		work_q.push_back('{kind, op, off, a, b, wr});
	endtask

	initial begin
		{core_op_valid, core_write_file, wdt_timeout_event, sleep_event, wdt_clear_event} = '0;
		core_op = OP_MOVE;
		{core_file_offset, core_operand_a, core_operand_b} = '0;
	end

	always @(posedge core_clk) begin
		if (!reset && wait_left == 0 && work_q.size() > 0) begin
			cur = work_q.pop_front();
			wait_left <= gap;
			core_op_valid <= cur.kind == 0;
			core_op <= cur.op;
			core_file_offset <= 7'(cur.off);
			core_operand_a <= 8'(cur.a);
			core_operand_b <= 8'(cur.b);
			core_write_file <= cur.wr;
			{wdt_timeout_event, sleep_event, wdt_clear_event} <= {cur.kind == 1, cur.kind == 2, cur.kind == 3};
		end else begin
			// operands wander while idle so nothing leans on stale values
			wait_left <= (reset || wait_left == 0) ? 0 : wait_left - 1;
			core_op_valid <= 1'b0;
			core_operand_a <= ~core_operand_a;
			core_operand_b <= core_operand_b + 8'h3b;
			{wdt_timeout_event, sleep_event, wdt_clear_event} <= 3'b000;
		end
	end
endmodule

// *** sim/bank3_sfr_map_status_reg_bench.sv ***
// self-checking bench: APB master, core model and a reference of the bank
// assumes pready answers each access and one core op is taken per cycle
`timescale 1ns/1ps
module bank3_sfr_map_status_reg_bench;
	import sfr_bank3_pkg::*;
	logic                core_clk = 1'b0;
	logic                reset = 1'b1;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [PADDR_W-1:0]  paddr = '0;
	logic [31:0]         pwdata = '0;
	logic [31:0]         prdata;
	logic                pready, pslverr, core_op_valid, core_write_file;
	logic                wdt_timeout_event, sleep_event, wdt_clear_event;
	alu_op_type          core_op;
	logic [OFFS_W-1:0]   core_file_offset;
	logic [DATA_W-1:0]   core_operand_a, core_operand_b, core_read_data, alu_result;
	logic [ADDR_W-1:0]   effective_address;
	logic [DATA_W-1:0]   processor_status, timer_and_pullup_options, program_counter_low;
	logic [DATA_W-1:0]   indirect_pointer, port_b_direction, program_counter_high_buffer, interrupt_control;
	int                  regs[16];
	int                  exp_alu, rd_exp, bad_count = 0, n_compared = 0;
	bit                  alu_known, rd_due;
	alu_op_type          ops[5] = '{OP_MOVE, OP_LOGIC, OP_ADD, OP_SUB, OP_CLEAR};
	int                  offs[10] = '{0, 1, 2, 3, 4, 5, 6, 'ha, 'hb, 'hc};
	int                  ta[6] = '{5, 0, 'h10, 'hff, 'h0f, 0};
	int                  tb[6] = '{5, 1, 1, 1, 1, 0};

	core_exec_model partner (.core_clk, .reset, .core_op_valid, .core_op, .core_file_offset, .core_operand_a,
		.core_operand_b, .core_write_file, .wdt_timeout_event, .sleep_event, .wdt_clear_event);
	bank3_sfr_map_status_reg dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .core_op_valid, .core_op, .core_file_offset, .core_operand_a, .core_operand_b,
		.core_write_file, .wdt_timeout_event, .sleep_event, .wdt_clear_event, .core_read_data, .alu_result,
		.effective_address, .processor_status, .timer_and_pullup_options, .program_counter_low,
		.indirect_pointer, .port_b_direction, .program_counter_high_buffer, .interrupt_control);

	always #20 core_clk = ~core_clk;

	function automatic int dec(input int a);
		int o;
		o = a & 'h7f;
		if (o inside {2, 3, 4, 'ha, 'hb} || ((a & 'h80) != 0 && o inside {1, 6}))
			return o;
		return -1;
	endfunction

	function automatic int ea_of(input int off);
		if (off == 0)
			return ((regs[3] >> 7) << 8) | regs[4];
		return (((regs[3] >> 5) & 3) << 7) | off;
	endfunction

	// bits 4:3 of status never follow data
	function automatic void put(input int i, input int v);
		if (i == 3)
			regs[3] = (v & 'he7) | (regs[3] & 'h18);
		else if (i >= 0)
			regs[i] = v & (i == 'ha ? 'h1f : 'hff);
	endfunction

	function automatic void set_bit(input int pos, input bit v);
		regs[3] = v ? regs[3] | (1 << pos) : regs[3] & ~(1 << pos);
	endfunction

	function automatic void core_step(input alu_op_type op, input int off, input int a, input int b,
		input bit wr);
		int i, res;
		res = op == OP_ADD ? a + b : op == OP_SUB ? a - b : op == OP_CLEAR ? 0 : a;
		i = dec(ea_of(off));
		rd_exp = i < 0 ? 0 : regs[i];
		if (wr && i == 3 && op != OP_MOVE)
			regs[3] = (res & 'he0) | (regs[3] & 'h1f);
		else if (wr)
			put(i, res);
		if (op != OP_MOVE)
			set_bit(ST_Z, (res & 'hff) == 0);
		if (op == OP_ADD || op == OP_SUB) begin
			set_bit(ST_C, op == OP_ADD ? a + b > 255 : a >= b);
			set_bit(ST_NIBBLE, op == OP_ADD ? (a & 15) + (b & 15) > 15 : (a & 15) >= (b & 15));
		end
		exp_alu = res & 'hff;
		alu_known = 1;
	endfunction

	always @(posedge core_clk) begin
		rd_due = core_op_valid === 1'b1;
		if (reset) begin
			regs = '{1: 'hff, 3: 'h18, 6: 'hff, default: 0};
			alu_known = 0;
		end else if (core_op_valid === 1'b1)
			core_step(core_op, core_file_offset, core_operand_a, core_operand_b, core_write_file);
		else if (wdt_timeout_event === 1'b1)
			set_bit(ST_WDOG, 0);
		else if (sleep_event === 1'b1 || wdt_clear_event === 1'b1) begin
			set_bit(ST_WDOG, 1);
			set_bit(ST_SLEEP, wdt_clear_event);
		end
	end

	task automatic check_reg(input logic [8:0] got, input int exp, input string what);
		n_compared++;
		if (got !== 9'(exp)) begin
			bad_count++;
			$display("unexpected %s at %0t: got %h want %h", what, $time, got, 9'(exp));
		end
	endtask

	task automatic check_bus(input logic [31:0] got, input int exp, input string what);
		n_compared++;
		if (got !== 32'(exp)) begin
			bad_count++;
			$display("unexpected %s at %0t: got %h want %h", what, $time, got, 32'(exp));
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(negedge core_clk) begin
		if (!reset) begin
			check_reg(processor_status, regs[3], "status");
			check_reg(timer_and_pullup_options, regs[1], "options");
			check_reg(program_counter_low, regs[2], "pc low");
			check_reg(indirect_pointer, regs[4], "pointer");
			check_reg(port_b_direction, regs[6], "direction");
			check_reg(program_counter_high_buffer, regs['ha], "pc high");
			check_reg(interrupt_control, regs['hb], "int ctrl");
			if (alu_known)
				check_reg(alu_result, exp_alu, "alu result");
			if (core_op_valid === 1'b1)
				check_reg(effective_address, ea_of(core_file_offset), "address");
			if (rd_due)
				check_reg(core_read_data, rd_exp, "core read");
		end
	end

	task automatic apb(input bit wr, input int idx, input int wd);
		int n, i;
		bit out;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= PADDR_W'(idx * 4);
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		if (n >= 200) begin
			bad_count++;
			give_verdict();
		end
		out = idx < 'h180 || idx > 'h19f;
		i = out ? -1 : dec(idx);
		check_bus(pslverr, out, "error flag");
		if (!wr)
			check_bus(prdata, i < 0 ? 0 : regs[i], "read data");
		else
			put(i, wd);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic drain();
		int n;
		for (n = 0; n < 1000 && (partner.work_q.size() > 0 || partner.wait_left > 0); n++)
			@(posedge core_clk);
		repeat (2) @(posedge core_clk);
		if (n >= 1000) begin
			bad_count++;
			give_verdict();
		end
	endtask

	initial begin
		int i, k, g;
		void'($urandom(32'hadaf));
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		for (i = 'h17e; i <= 'h1a1; i++)
			apb(0, i, 0);
		for (k = 0; k < 2; k++)
			for (i = 'h17e; i <= 'h1a1; i++)
				apb(k == 0, i, $urandom());
		for (k = 1; k <= 3; k++) begin
			partner.issue(k, OP_MOVE, 0, 0, 0, 0);
			drain();
			apb(1, 'h183, $urandom());
		end
		// each bank: direct steering, aliased core registers, clear of status
		for (k = 0; k < 4; k++) begin
			apb(1, 'h183, (k << 5) | 'h83);
			partner.issue(0, OP_MOVE, 5, 0, 0, 0);
			partner.issue(0, OP_MOVE, 4, $urandom(), 0, 1);
			partner.issue(0, OP_MOVE, 6, $urandom(), 0, 1);
			partner.issue(0, OP_CLEAR, 3, $urandom(), $urandom(), 1);
			drain();
			apb(0, 'h184, 0);
		end
		partner.gap = 0;
		for (k = 0; k < 6; k++)
			partner.issue(0, k < 3 ? OP_SUB : OP_ADD, 3 + k % 2, ta[k], tb[k], 1);
		drain();
		// random streams, back to back then spaced, with APB stalled behind them
		for (g = 0; g < 2; g++) begin
			partner.gap = g;
			fork
				begin
					for (i = 0; i < 100; i++)
						partner.issue(0, ops[$urandom() % 5], offs[$urandom() % 10], $urandom() % 256,
							$urandom() % 256, $urandom() % 2);
					drain();
				end
				for (k = 0; k < 30; k++)
					apb($urandom() % 2, 'h180 + $urandom() % 32, $urandom());
			join
		end
		give_verdict();
	end
endmodule
